/* File: xma_pkg.sv */
// Package for the extended memory ALU datapath: opcodes, flag layout, carriers
package xma_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int XMA_DW = 8;
  localparam int XMA_AW = 12;

  // ****************************************
  // Reset values and data constants
  // ****************************************
  localparam logic [7:0] XMA_WORKING_RST = 8'h00;
  localparam logic [7:0] XMA_ALL_ONES = 8'hff;
  localparam logic [7:0] XMA_ONE = 8'h01;

  // ****************************************
  // Timing counts
  // ****************************************
  localparam logic [1:0] XMA_SKIP_CYCLES = 2'h3;
  localparam logic [1:0] XMA_PLAIN_CYCLES = 2'h1;

  // ****************************************
  // Flag field positions
  // ****************************************
  localparam int XMA_FLAG_CARRY = 0;
  localparam int XMA_FLAG_NIBBLE = 1;
  localparam int XMA_FLAG_ZERO = 2;
  localparam int XMA_FLAG_RANGE = 3;
  localparam int XMA_FLAG_SIGNCMP = 4;
  localparam int XMA_FLAG_BORROWZ = 5;
  localparam logic [5:0] XMA_FLAGS_RST = 6'h00;

  typedef enum logic [4:0] {
    XMA_OP_NONE = 5'h00,
    XMA_OP_MOVE_WORKING_TO_MEM = 5'h01,
    XMA_OP_OR_MEM_INTO_WORKING = 5'h02,
    XMA_OP_OR_INTO_MEM = 5'h03,
    XMA_OP_ROTATE_LEFT_MEM = 5'h04,
    XMA_OP_ROTATE_LEFT_TO_WORKING = 5'h05,
    XMA_OP_ROTATE_LEFT_THRU_CARRY = 5'h06,
    XMA_OP_ROTATE_LEFT_THRU_CARRY_TO_WORKING = 5'h07,
    XMA_OP_ROTATE_RIGHT_MEM = 5'h08,
    XMA_OP_ROTATE_RIGHT_TO_WORKING = 5'h09,
    XMA_OP_ROTATE_RIGHT_THRU_CARRY = 5'h0a,
    XMA_OP_ROTATE_RIGHT_THRU_CARRY_TO_WORKING = 5'h0b,
    XMA_OP_SUBTRACT_BORROW_TO_WORKING = 5'h0c,
    XMA_OP_SUBTRACT_BORROW_TO_MEM = 5'h0d,
    XMA_OP_DECREMENT_SKIP_ZERO = 5'h0e,
    XMA_OP_DECREMENT_SKIP_ZERO_TO_WORKING = 5'h0f,
    XMA_OP_SET_MEM_BITS = 5'h10,
    XMA_OP_SET_MEM_BIT = 5'h11,
    XMA_OP_INCREMENT_SKIP_ZERO = 5'h12,
    XMA_OP_INCREMENT_SKIP_ZERO_TO_WORKING = 5'h13,
    XMA_OP_TEST_SKIP_NONZERO = 5'h14,
    XMA_OP_TEST_BIT_SKIP_NONZERO = 5'h15,
    XMA_OP_SUBTRACT_TO_WORKING = 5'h16,
    XMA_OP_SUBTRACT_TO_MEM = 5'h17
  } xma_op_t;

  typedef enum logic [1:0] {
    XMA_ST_IDLE = 2'b00,
    XMA_ST_EXEC = 2'b01,
    XMA_ST_DUMMY = 2'b11
  } xma_state_t;

  typedef struct packed {
    xma_op_t op;
    logic [XMA_AW-1:0] addr;
    logic [2:0] bitSel;
  } xma_cmd_t;

  typedef struct packed {
    logic wrEn;
    logic [XMA_AW-1:0] addr;
    logic [XMA_DW-1:0] data;
  } xma_memwr_t;

endpackage : xma_pkg

/* File: xma_extended_mem_alu_ops.sv */
// Extended memory ALU datapath: moves, OR, rotates, subtracts, set, skip forms
// What this block does
// - Operand address reaches all memory, no banking
// - Move working to memory, flags untouched
// - OR to working or memory, zero only
// - Rotate left, bit7 to bit0, no flags
// - Rotate left through carry, carry only
// - Rotate right, bit0 to bit7, no flags
// - Rotate right through carry, carry only
// - Working minus memory minus inverted carry
// - Working minus memory, six arithmetic flags
// - Carry clear if negative, else set
// - Decrement memory, skip when zero
// - Decrement to working, skip when zero
// - Byte set writes all ones
// - Bit set forces selected bit one
// - Increment memory, skip when zero
// - Increment to working, skip when zero
// - Bit test skips when bit is one
// - Byte test rewrites, skips when nonzero
// - Skip forms take three cycles
`timescale 1ns/1ps
module xma_extended_mem_alu_ops
  import xma_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmdValid,
  input xma_cmd_t cmd,
  input wire logic [XMA_DW-1:0] memRdData,
  output logic cmdReady,
  output logic [XMA_AW-1:0] memRdAddr,
  output xma_memwr_t memWr,
  output logic [XMA_DW-1:0] working,
  output logic [5:0] flags,
  output logic skipNext,
  output logic done
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic isZero(input logic [XMA_DW-1:0] v);
    isZero = (v == 8'h00);
  endfunction : isZero

  // Skip forms hold the datapath for a dummy cycle
  function automatic logic isSkipOp(input xma_op_t op);
    case (op)
      XMA_OP_DECREMENT_SKIP_ZERO,
      XMA_OP_DECREMENT_SKIP_ZERO_TO_WORKING,
      XMA_OP_INCREMENT_SKIP_ZERO,
      XMA_OP_INCREMENT_SKIP_ZERO_TO_WORKING,
      XMA_OP_TEST_SKIP_NONZERO,
      XMA_OP_TEST_BIT_SKIP_NONZERO: begin
        isSkipOp = 1'b1;
      end
      default: begin
        isSkipOp = 1'b0;
      end
    endcase
  endfunction : isSkipOp

  function automatic logic [1:0] opCycles(input xma_op_t op);
    opCycles = isSkipOp(op) ? XMA_SKIP_CYCLES : XMA_PLAIN_CYCLES;
  endfunction : opCycles

  // ****************************************
  // State
  // ****************************************
  xma_state_t state;
  xma_state_t next_state;
  xma_cmd_t held;
  logic [1:0] cycleLeft;

  // Operands are taken from memory in the execute cycle; whole-range address
  assign memRdAddr = held.addr;

  // ****************************************
  // Datapath
  // ****************************************
  wire logic [XMA_DW-1:0] m = memRdData;
  wire logic cIn = flags[XMA_FLAG_CARRY];
  wire logic useBorrow = (held.op == XMA_OP_SUBTRACT_BORROW_TO_WORKING) ||
                         (held.op == XMA_OP_SUBTRACT_BORROW_TO_MEM);
  wire logic borrowIn = useBorrow & ~cIn;
  wire logic [8:0] subFull = {1'b0, working} - {1'b0, m} - {8'h00, borrowIn};
  wire logic [4:0] subLow = {1'b0, working[3:0]} - {1'b0, m[3:0]} - {4'h0, borrowIn};
  wire logic [XMA_DW-1:0] subRes = subFull[7:0];
  wire logic subCarry = ~subFull[8];
  wire logic subRange = (working[7] ^ m[7]) & (working[7] ^ subRes[7]);
  wire logic subSignCmp = subRange ^ subRes[7];
  wire logic subZero = isZero(subRes);
  wire logic subBorrowZero = useBorrow ? (subZero & flags[XMA_FLAG_ZERO]) : subZero;
  wire logic [XMA_DW-1:0] orRes = working | m;
  wire logic [XMA_DW-1:0] rlRes = {m[6:0], m[7]};
  wire logic [XMA_DW-1:0] rlcRes = {m[6:0], cIn};
  wire logic [XMA_DW-1:0] rrRes = {m[0], m[7:1]};
  wire logic [XMA_DW-1:0] rrcRes = {cIn, m[7:1]};
  wire logic [XMA_DW-1:0] decRes = m - XMA_ONE;
  wire logic [XMA_DW-1:0] incRes = m + XMA_ONE;
  wire logic [XMA_DW-1:0] bitMask = XMA_ONE << held.bitSel;
  wire logic [XMA_DW-1:0] bitSetRes = m | bitMask;
  wire logic bitIsOne = |(m & bitMask);

  // ****************************************
  // Result selection
  // ****************************************
  logic [XMA_DW-1:0] res;
  logic toMem;
  logic toWorking;
  logic setZero;
  logic setCarry;
  logic newCarry;
  logic setArith;
  logic skipCond;
  logic isSkip;

  always_comb begin
    res = m;
    toMem = 1'b0;
    toWorking = 1'b0;
    setZero = 1'b0;
    setCarry = 1'b0;
    newCarry = cIn;
    setArith = 1'b0;
    skipCond = 1'b0;
    isSkip = 1'b0;
    case (held.op)
      XMA_OP_MOVE_WORKING_TO_MEM: begin
        res = working;
        toMem = 1'b1;
      end
      XMA_OP_OR_MEM_INTO_WORKING: begin
        res = orRes;
        toWorking = 1'b1;
        setZero = 1'b1;
      end
      XMA_OP_OR_INTO_MEM: begin
        res = orRes;
        toMem = 1'b1;
        setZero = 1'b1;
      end
      XMA_OP_ROTATE_LEFT_MEM: begin
        res = rlRes;
        toMem = 1'b1;
      end
      XMA_OP_ROTATE_LEFT_TO_WORKING: begin
        res = rlRes;
        toWorking = 1'b1;
      end
      XMA_OP_ROTATE_LEFT_THRU_CARRY: begin
        res = rlcRes;
        toMem = 1'b1;
        setCarry = 1'b1;
        newCarry = m[7];
      end
      XMA_OP_ROTATE_LEFT_THRU_CARRY_TO_WORKING: begin
        res = rlcRes;
        toWorking = 1'b1;
        setCarry = 1'b1;
        newCarry = m[7];
      end
      XMA_OP_ROTATE_RIGHT_MEM: begin
        res = rrRes;
        toMem = 1'b1;
      end
      XMA_OP_ROTATE_RIGHT_TO_WORKING: begin
        res = rrRes;
        toWorking = 1'b1;
      end
      XMA_OP_ROTATE_RIGHT_THRU_CARRY: begin
        res = rrcRes;
        toMem = 1'b1;
        setCarry = 1'b1;
        newCarry = m[0];
      end
      XMA_OP_ROTATE_RIGHT_THRU_CARRY_TO_WORKING: begin
        res = rrcRes;
        toWorking = 1'b1;
        setCarry = 1'b1;
        newCarry = m[0];
      end
      XMA_OP_SUBTRACT_BORROW_TO_WORKING, XMA_OP_SUBTRACT_TO_WORKING: begin
        res = subRes;
        toWorking = 1'b1;
        setArith = 1'b1;
      end
      XMA_OP_SUBTRACT_BORROW_TO_MEM, XMA_OP_SUBTRACT_TO_MEM: begin
        res = subRes;
        toMem = 1'b1;
        setArith = 1'b1;
      end
      XMA_OP_DECREMENT_SKIP_ZERO: begin
        res = decRes;
        toMem = 1'b1;
        isSkip = 1'b1;
        skipCond = isZero(decRes);
      end
      XMA_OP_DECREMENT_SKIP_ZERO_TO_WORKING: begin
        res = decRes;
        toWorking = 1'b1;
        isSkip = 1'b1;
        skipCond = isZero(decRes);
      end
      XMA_OP_SET_MEM_BITS: begin
        res = XMA_ALL_ONES;
        toMem = 1'b1;
      end
      XMA_OP_SET_MEM_BIT: begin
        res = bitSetRes;
        toMem = 1'b1;
      end
      XMA_OP_INCREMENT_SKIP_ZERO: begin
        res = incRes;
        toMem = 1'b1;
        isSkip = 1'b1;
        skipCond = isZero(incRes);
      end
      XMA_OP_INCREMENT_SKIP_ZERO_TO_WORKING: begin
        res = incRes;
        toWorking = 1'b1;
        isSkip = 1'b1;
        skipCond = isZero(incRes);
      end
      XMA_OP_TEST_BIT_SKIP_NONZERO: begin
        isSkip = 1'b1;
        skipCond = bitIsOne;
      end
      XMA_OP_TEST_SKIP_NONZERO: begin
        res = m;
        toMem = 1'b1;
        isSkip = 1'b1;
        skipCond = ~isZero(m);
      end
      default: begin
        res = m;
      end
    endcase
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Plain forms commit in their only execute cycle
  wire logic execNow = (state == XMA_ST_EXEC) && (cycleLeft == XMA_PLAIN_CYCLES);
  wire logic firstExec = (state == XMA_ST_EXEC) && (cycleLeft != XMA_PLAIN_CYCLES);
  assign cmdReady = (state == XMA_ST_IDLE);
  wire logic takeCmd = cmdReady && cmdValid;

  always_comb begin
    next_state = state;
    case (state)
      XMA_ST_IDLE: begin
        if (cmdValid) begin
          next_state = XMA_ST_EXEC;
        end
      end
      XMA_ST_EXEC: begin
        if (execNow) begin
          next_state = XMA_ST_IDLE;
        end else begin
          next_state = XMA_ST_DUMMY;
        end
      end
      XMA_ST_DUMMY: begin
        next_state = XMA_ST_EXEC;
      end
      default: begin
        next_state = XMA_ST_IDLE;
      end
    endcase
  end

  // Skip forms walk exec, dummy, exec: three cycles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= XMA_ST_IDLE;
      held <= '0;
      cycleLeft <= XMA_PLAIN_CYCLES;
    end else begin
      state <= next_state;
      if (takeCmd) begin
        held <= cmd;
        cycleLeft <= opCycles(cmd.op);
      end else if (firstExec) begin
        cycleLeft <= XMA_PLAIN_CYCLES;
      end
    end
  end

  // ****************************************
  // Commit
  // ****************************************
  wire logic commit = (state == XMA_ST_EXEC) && (!isSkip || firstExec == 1'b0) &&
                      (isSkip ? (cycleLeft == XMA_PLAIN_CYCLES) : 1'b1);

  // ****************************************
  // Flag update
  // ****************************************
  // Only the flags an operation names change; the rest hold
  logic [5:0] next_flags;

  always_comb begin
    next_flags = flags;
    if (setZero) begin
      next_flags[XMA_FLAG_ZERO] = isZero(res);
    end
    if (setCarry) begin
      next_flags[XMA_FLAG_CARRY] = newCarry;
    end
    if (setArith) begin
      next_flags[XMA_FLAG_CARRY] = subCarry;
      next_flags[XMA_FLAG_ZERO] = subZero;
      next_flags[XMA_FLAG_NIBBLE] = ~subLow[4];
      next_flags[XMA_FLAG_RANGE] = subRange;
      next_flags[XMA_FLAG_SIGNCMP] = subSignCmp;
      next_flags[XMA_FLAG_BORROWZ] = subBorrowZero;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      working <= XMA_WORKING_RST;
      flags <= XMA_FLAGS_RST;
      memWr <= '0;
      skipNext <= 1'b0;
      done <= 1'b0;
    end else begin
      memWr.wrEn <= commit && toMem;
      memWr.addr <= held.addr;
      memWr.data <= res;
      skipNext <= commit && isSkip && skipCond;
      done <= commit;
      if (commit && toWorking) begin
        working <= res;
      end
      if (commit) begin
        flags <= next_flags;
      end
    end
  end

endmodule : xma_extended_mem_alu_ops

/* File: xma_asserts.sv */
// Checker of the extended memory ALU datapath ports
`timescale 1ns/1ps
module xma_asserts
  import xma_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmdValid,
  input xma_cmd_t cmd,
  input wire logic [XMA_DW-1:0] memRdData,
  input wire logic cmdReady,
  input wire logic [XMA_AW-1:0] memRdAddr,
  input xma_memwr_t memWr,
  input wire logic [XMA_DW-1:0] working,
  input wire logic [5:0] flags,
  input wire logic skipNext,
  input wire logic done
);
  // ********
  // Last accepted operation
  // ********
  xma_op_t lastOp;
  logic lastSkip;
  wire logic take = cmdValid && cmdReady;
  wire logic skipCmd = cmd.op inside {[5'h0e:5'h0f], [5'h12:5'h15]};
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lastOp <= XMA_OP_NONE;
      lastSkip <= 1'b0;
    end else if (take) begin
      lastOp <= cmd.op;
      lastSkip <= skipCmd;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ********
  // Checks
  // ********
  a_plain_latency: assert property (take && !skipCmd |-> ##1 !done ##1 done)
    else $error("plain latency");
  a_skip_latency: assert property (take && skipCmd |-> ##1 !done [*3] ##1 done)
    else $error("skip latency");
  a_skip_cause: assert property (skipNext |-> done && lastSkip)
    else $error("stray skip");
  a_read_addr: assert property (take |=> memRdAddr == $past(cmd.addr))
    else $error("read address");
  a_move_copy: assert property (done && lastOp == XMA_OP_MOVE_WORKING_TO_MEM |->
    memWr.wrEn && memWr.data == working && $stable(flags)) else $error("move");
  a_set_ones: assert property (done && lastOp == XMA_OP_SET_MEM_BITS |->
    memWr.wrEn && memWr.data == 8'hff) else $error("byte set");
  a_rotl_data: assert property (done && lastOp == XMA_OP_ROTATE_LEFT_MEM |->
    memWr.data == {memRdData[6:0], memRdData[7]} && $stable(flags)) else $error("rotate");
  a_or_data: assert property (done && lastOp == XMA_OP_OR_INTO_MEM |->
    memWr.data == (working | memRdData)) else $error("or to memory");
  a_skip_flags: assert property (done && lastSkip |-> $stable(flags))
    else $error("skip op flags");
  c_skip_seen: cover property (skipNext);
  c_sub_mem: cover property (done && lastOp == XMA_OP_SUBTRACT_BORROW_TO_MEM);
  c_plain_take: cover property (take && !skipCmd);
endmodule : xma_asserts

/* File: test_extended_mem_alu_ops.sv */
// Self-checking testbench of the extended memory ALU datapath
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module test_extended_mem_alu_ops;
  import xma_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cmdValid = 1'b0;
  xma_cmd_t cmd = '0;
  logic [7:0] memRdData;
  logic cmdReady;
  logic [XMA_AW-1:0] memRdAddr;
  xma_memwr_t memWr;
  logic [7:0] working;
  logic [5:0] flags;
  logic skipNext;
  logic done;
  logic [7:0] mem [0:4095];
  logic [7:0] expW = 8'h00;
  logic [5:0] expF = 6'h00;
  int errors = 0;
  int tests_run = 0;

  always #2.5 core_clk = ~core_clk;
  assign memRdData = mem[memRdAddr];
  always @(posedge core_clk) if (memWr.wrEn) mem[memWr.addr] <= memWr.data;

  xma_extended_mem_alu_ops u_xma_extended_mem_alu_ops (.core_clk, .rst, .cmdValid, .cmd,
    .memRdData, .cmdReady, .memRdAddr, .memWr, .working, .flags, .skipNext, .done);

  // ********
  // Shared tasks
  // ********
  task automatic t(input xma_op_t op, input logic [11:0] a, input logic [2:0] b,
      input logic [7:0] m, input logic [7:0] em, input logic es, input int el);
    int lat;
    logic sk;
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmd <= '{op, a, b};
    mem[a] <= m;
    @(posedge core_clk);
    cmdValid <= 1'b0;
    lat = 1;
    do begin
      @(posedge core_clk);
      #1;
      lat++;
    end while (done !== 1'b1 && lat < 9);
    sk = skipNext;
    @(posedge core_clk);
    #1;
    `CHK(lat, el)
    `CHK(sk, es)
    `CHK(mem[a], em)
    `CHK(working, expW)
    `CHK(flags, expF)
  endtask : t

  task automatic setW(input logic [7:0] v);
    expW = v;
    t(XMA_OP_ROTATE_LEFT_TO_WORKING, 12'h3ff, 3'h0, {v[0], v[7:1]}, {v[0], v[7:1]}, 1'b0,
      2);
  endtask : setW

  task automatic setC(input logic c);
    expW = {7'h00, expF[XMA_FLAG_CARRY]};
    expF[XMA_FLAG_CARRY] = c;
    t(XMA_OP_ROTATE_LEFT_THRU_CARRY_TO_WORKING, 12'h3fe, 3'h0, {c, 7'h00}, {c, 7'h00}, 1'b0,
      2);
  endtask : setC

  // ********
  // Scenarios
  // ********
  task automatic t_logic();
    expF[XMA_FLAG_ZERO] = 1'b1;
    t(XMA_OP_OR_MEM_INTO_WORKING, 12'h000, 3'h0, 8'h00, 8'h00, 1'b0, 2);
    expW = 8'h5a;
    expF[XMA_FLAG_ZERO] = 1'b0;
    t(XMA_OP_OR_MEM_INTO_WORKING, 12'h001, 3'h0, 8'h5a, 8'h5a, 1'b0, 2);
    t(XMA_OP_OR_INTO_MEM, 12'h002, 3'h0, 8'h81, 8'hdb, 1'b0, 2);
    t(XMA_OP_MOVE_WORKING_TO_MEM, 12'hfff, 3'h0, 8'h00, 8'h5a, 1'b0, 2);
    t(XMA_OP_SET_MEM_BITS, 12'h800, 3'h0, 8'h12, 8'hff, 1'b0, 2);
    for (int i = 0; i < 8; i++) begin
      t(XMA_OP_SET_MEM_BIT, 12'h801, i[2:0], 8'ha5, 8'ha5 | (8'h01 << i), 1'b0, 2);
    end
  endtask : t_logic

  task automatic t_rot();
    setC(1'b0);
    t(XMA_OP_ROTATE_LEFT_MEM, 12'h200, 3'h0, 8'h81, 8'h03, 1'b0, 2);
    t(XMA_OP_ROTATE_RIGHT_MEM, 12'h201, 3'h0, 8'h81, 8'hc0, 1'b0, 2);
    expW = 8'h81;
    t(XMA_OP_ROTATE_RIGHT_TO_WORKING, 12'h202, 3'h0, 8'h03, 8'h03, 1'b0, 2);
    expF[XMA_FLAG_CARRY] = 1'b1;
    t(XMA_OP_ROTATE_LEFT_THRU_CARRY, 12'h203, 3'h0, 8'h81, 8'h02, 1'b0, 2);
    expF[XMA_FLAG_CARRY] = 1'b0;
    t(XMA_OP_ROTATE_RIGHT_THRU_CARRY, 12'h204, 3'h0, 8'h02, 8'h81, 1'b0, 2);
    expW = 8'h40;
    expF[XMA_FLAG_CARRY] = 1'b1;
    t(XMA_OP_ROTATE_RIGHT_THRU_CARRY_TO_WORKING, 12'h205, 3'h0, 8'h81, 8'h81, 1'b0,
      2);
  endtask : t_rot

  task automatic t_sub();
    logic [7:0] wv [7] = '{8'h50, 8'h30, 8'h80, 8'h42, 8'h10, 8'h10, 8'h7f};
    logic [7:0] mv [7] = '{8'h30, 8'h50, 8'h01, 8'h42, 8'h0f, 8'h20, 8'hff};
    logic [6:0] cv = 7'b1100101;
    logic [6:0] bv = 7'b1110000;
    logic [6:0] mf = 7'b1001000;
    logic [7:0] r;
    logic bw;
    xma_op_t op;
    for (int i = 0; i < 7; i++) begin
      setC(cv[i]);
      setW(wv[i]);
      bw = bv[i] & ~cv[i];
      r = wv[i] - mv[i] - bw;
      expF[XMA_FLAG_CARRY] = {1'b0, wv[i]} >= {1'b0, mv[i]} + bw;
      expF[XMA_FLAG_NIBBLE] = {1'b0, wv[i][3:0]} >= {1'b0, mv[i][3:0]} + bw;
      expF[XMA_FLAG_RANGE] = (wv[i][7] ^ mv[i][7]) & (r[7] ^ wv[i][7]);
      expF[XMA_FLAG_SIGNCMP] = expF[XMA_FLAG_RANGE] ^ r[7];
      expF[XMA_FLAG_BORROWZ] = (r == 8'h00) & (~bv[i] | expF[XMA_FLAG_ZERO]);
      expF[XMA_FLAG_ZERO] = r == 8'h00;
      op = bv[i] ? (mf[i] ? XMA_OP_SUBTRACT_BORROW_TO_MEM : XMA_OP_SUBTRACT_BORROW_TO_WORKING)
        : (mf[i] ? XMA_OP_SUBTRACT_TO_MEM : XMA_OP_SUBTRACT_TO_WORKING);
      if (!mf[i]) expW = r;
      t(op, 12'h300, 3'h0, mv[i], mf[i] ? r : mv[i], 1'b0, 2);
    end
  endtask : t_sub

  task automatic t_skip();
    logic [7:0] tb = 8'h5a;
    t(XMA_OP_DECREMENT_SKIP_ZERO, 12'h400, 3'h0, 8'h01, 8'h00, 1'b1, 4);
    expW = 8'hff;
    t(XMA_OP_DECREMENT_SKIP_ZERO_TO_WORKING, 12'h401, 3'h0, 8'h00, 8'h00, 1'b0, 4);
    t(XMA_OP_INCREMENT_SKIP_ZERO, 12'h402, 3'h0, 8'hff, 8'h00, 1'b1, 4);
    expW = 8'h11;
    t(XMA_OP_INCREMENT_SKIP_ZERO_TO_WORKING, 12'h403, 3'h0, 8'h10, 8'h10, 1'b0, 4);
    t(XMA_OP_TEST_SKIP_NONZERO, 12'h404, 3'h0, 8'h00, 8'h00, 1'b0, 4);
    t(XMA_OP_TEST_SKIP_NONZERO, 12'h404, 3'h0, 8'h10, 8'h10, 1'b1, 4);
    for (int i = 0; i < 8; i++) begin
      t(XMA_OP_TEST_BIT_SKIP_NONZERO, 12'h405, i[2:0], tb, tb, tb[i], 4);
    end
  endtask : t_skip

  task automatic test_done();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_logic();
    t_rot();
    t_sub();
    t_skip();
    test_done();
  end

  initial begin
    #20000;
    errors++;
    test_done();
  end
endmodule : test_extended_mem_alu_ops

bind xma_extended_mem_alu_ops xma_asserts u_xma_asserts (.core_clk, .rst, .cmdValid, .cmd,
  .memRdData, .cmdReady, .memRdAddr, .memWr, .working, .flags, .skipNext, .done);
